// ===== logic/dacr_defs.vh
// Operation
// RQ1 - per channel sixteen bit primary RAM start
// RQ2 - per channel sixteen bit secondary RAM start
// RQ3 - primary read returns current working address
// RQ4 - secondary read returns current working address
// RQ5 - per channel sixteen bit peripheral address
// RQ6 - transfers per block equal count plus one
// RQ7 - count upper six bits read zero
// RQ8 - software avoids writes while channel enabled
// RQ9 - all implemented bits zero after reset
// RQ10 - low status byte flags RAM collisions
// RQ11 - high status byte sticky peripheral collisions
`ifndef DACR_DEFS_VH
`define DACR_DEFS_VH
// ****************************************
// register map, channel block of 16 bytes
// ****************************************
`define DACR_CH_STRIDE 7'h10
`define DACR_OFF_PRI 4'h0
`define DACR_OFF_SEC 4'h4
`define DACR_OFF_PAD 4'h8
`define DACR_OFF_CNT 4'hC
`define DACR_OFF_STAT 8'h80
`define DACR_OFF_MASK 8'h84
`define DACR_OFF_CTRL 8'h88
// ****************************************
// fields and reset values
// ****************************************
`define DACR_CNT_W 10
`define DACR_PCOL_LSB 8
`define DACR_XCOL_LSB 0
`define DACR_RST16 16'h0000
`define DACR_RST8 8'h00
`endif

// ===== logic/dacr_chan.v
`include "dacr_defs.vh"
// one channel: stored addresses/count plus working address and block counter
module dacr_chan (
   // clock
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   // software writes
   input wire wr_pri_i,
   input wire wr_sec_i,
   input wire wr_pad_i,
   input wire wr_cnt_i,
   input wire [15:0] wdat_i,
   // channel control
   input wire en_i,
   input wire sel_sec_i,
   input wire xfer_i,
   // state
   output wire [15:0] pri_o,
   output wire [15:0] sec_o,
   output wire [15:0] pad_o,
   output wire [9:0] cnt_o,
   output wire [15:0] work_o,
   output wire done_o
);
   reg [15:0] pri_q;
   reg [15:0] sec_q;
   reg [15:0] pad_q;
   reg [9:0] cnt_q;
   reg [15:0] work_q;
   reg [9:0] idx_q;
   reg en_q;
   wire last = (idx_q == cnt_q);
   always @(posedge clk_i) begin
      if (rst_i) begin
         pri_q <= `DACR_RST16; // [RQ9]
         sec_q <= `DACR_RST16;
         pad_q <= `DACR_RST16;
         cnt_q <= 10'h000;
         work_q <= `DACR_RST16;
         idx_q <= 10'h000;
         en_q <= 1'b0;
      end else if (ce_i) begin
         en_q <= en_i;
         if (wr_pri_i) pri_q <= wdat_i; // [RQ1]
         if (wr_sec_i) sec_q <= wdat_i; // [RQ2]
         if (wr_pad_i) pad_q <= wdat_i; // [RQ5]
         if (wr_cnt_i) cnt_q <= wdat_i[`DACR_CNT_W-1:0]; // [RQ7]
         // working address loads from the selected buffer on enable, steps by one word per transfer
         if (en_i && !en_q) begin
            work_q <= sel_sec_i ? sec_q : pri_q;
            idx_q <= 10'h000;
         end else if (en_i && xfer_i) begin
            if (last) begin
               work_q <= sel_sec_i ? sec_q : pri_q;
               idx_q <= 10'h000; // [RQ6]
            end else begin
               work_q <= work_q + 16'h0002;
               idx_q <= idx_q + 10'h001;
            end
         end
      end
   end
   assign pri_o = pri_q;
   assign sec_o = sec_q;
   assign pad_o = pad_q;
   assign cnt_o = cnt_q;
   assign work_o = work_q;
   assign done_o = en_i && xfer_i && last && en_q; // [RQ6]
endmodule // dacr_chan

// ===== logic/dacr_top.v
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`include "dacr_defs.vh"
module dacr_top (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   // wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [7:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   // channel events
   input wire [7:0] xfer_i,
   input wire [7:0] pcol_i,
   input wire [7:0] xcol_i,
   // channel outputs
   output reg [7:0] done_o,
   output reg irq_o
);

   // ****************************************
   // registers
   // ****************************************
   reg [15:0] stat_q;
   reg [15:0] mask_q;
   reg [7:0] en_q;
   reg [7:0] bsel_q;

   // ****************************************
   // bus request
   // ****************************************
   // ack low keeps a strobe that is still held from being taken twice
   wire req = cyc_i && stb_i && !ack_o;
   wire wr = req && we_i && ce_i;
   // only byte lanes 0 and 1 exist: all registers are 16 bits wide
   wire lo = sel_i[0];
   wire hi = sel_i[1];
   wire [15:0] wmask = {{8{hi}}, {8{lo}}};

   // ****************************************
   // channel blocks
   // ****************************************
   // each channel owns a 32-bit slot in pri, sec, pad and work, upper halves tied to zero; count packs 10 bits per channel
   wire [255:0] pri_w;
   wire [255:0] sec_w;
   wire [255:0] pad_w;
   wire [255:0] work_w;
   wire [79:0] cnt_w;
   wire [7:0] done_w;
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_ch
         // a half-word write would leave a start address torn, so both lanes are required
         wire chsel = wr && !adr_i[7] && (adr_i[6:4] == g) && hi && lo;
         wire wr_pri = chsel && (adr_i[3:0] == `DACR_OFF_PRI);
         wire wr_sec = chsel && (adr_i[3:0] == `DACR_OFF_SEC);
         wire wr_pad = chsel && (adr_i[3:0] == `DACR_OFF_PAD);
         wire wr_cnt = chsel && (adr_i[3:0] == `DACR_OFF_CNT);
         dacr_chan u_ch (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .wr_pri_i(wr_pri),
            .wr_sec_i(wr_sec),
            .wr_pad_i(wr_pad),
            .wr_cnt_i(wr_cnt),
            .wdat_i(dat_i[15:0]),
            .en_i(en_q[g]),
            .sel_sec_i(bsel_q[g]),
            .xfer_i(xfer_i[g]),
            .pri_o(pri_w[g*32 +: 16]),
            .sec_o(sec_w[g*32 +: 16]),
            .pad_o(pad_w[g*32 +: 16]),
            .cnt_o(cnt_w[g*10 +: 10]),
            .work_o(work_w[g*32 +: 16]),
            .done_o(done_w[g])
         );
         assign pri_w[g*32+16 +: 16] = 16'h0000;
         assign sec_w[g*32+16 +: 16] = 16'h0000;
         assign pad_w[g*32+16 +: 16] = 16'h0000;
         assign work_w[g*32+16 +: 16] = 16'h0000;
      end
   endgenerate

   // ****************************************
   // read mux
   // ****************************************
   // the channel field picks a channel first, then the offset picks its register
   wire [2:0] rch = adr_i[6:4];
   wire [3:0] roff = adr_i[3:0];
   wire [15:0] r_work = work_w[rch*32 +: 16];
   wire [15:0] r_pad = pad_w[rch*32 +: 16];
   wire [9:0] r_cnt = cnt_w[rch*10 +: 10];
   reg [31:0] rd_chan;
   reg [31:0] rd_glob;
   reg [31:0] rd;

   always @* begin
      rd_chan = 32'h00000000;
      case (roff)
         // both start address locations show the working address, not the written value
         `DACR_OFF_PRI: begin
            rd_chan = {16'h0000, r_work}; // [RQ3]
         end
         `DACR_OFF_SEC: begin
            rd_chan = {16'h0000, r_work}; // [RQ4]
         end
         `DACR_OFF_PAD: begin
            rd_chan = {16'h0000, r_pad}; // [RQ5]
         end
         `DACR_OFF_CNT: begin
            rd_chan = {22'h000000, r_cnt}; // [RQ7]
         end
         default: begin
            rd_chan = 32'h00000000;
         end
      endcase
   end

   always @* begin
      rd_glob = 32'h00000000;
      case (adr_i)
         `DACR_OFF_STAT: begin
            rd_glob = {16'h0000, stat_q};
         end
         `DACR_OFF_MASK: begin
            rd_glob = {16'h0000, mask_q};
         end
         `DACR_OFF_CTRL: begin
            rd_glob = {16'h0000, bsel_q, en_q};
         end
         default: begin
            rd_glob = 32'h00000000;
         end
      endcase
   end

   always @* begin
      if (adr_i[7]) begin
         rd = rd_glob;
      end else begin
         rd = rd_chan;
      end
   end

   // ****************************************
   // address decode
   // ****************************************
   wire hit_stat = (adr_i == `DACR_OFF_STAT);
   wire hit_mask = (adr_i == `DACR_OFF_MASK);
   wire hit_ctrl = (adr_i == `DACR_OFF_CTRL);
   wire wr_stat = wr && hit_stat;
   wire wr_mask = wr && hit_mask;
   // each control byte has its own lane, so enables and buffer selects can be written apart
   wire wr_en = wr && hit_ctrl && lo;
   wire wr_bsel = wr && hit_ctrl && hi;

   // ****************************************
   // collision flags
   // ****************************************
   // event word in register layout: peripheral collisions high, RAM collisions low
   wire [15:0] ev = {pcol_i, xcol_i};
   wire [15:0] clr = wr_stat ? (dat_i[15:0] & wmask) : 16'h0000;
   wire [15:0] stat_d;
   genvar gb;
   generate
      for (gb = 0; gb < 16; gb = gb + 1) begin : g_flag
         // set beats clear: losing a collision is worse than one spare interrupt; software cannot set
         assign stat_d[gb] = ev[gb] | (stat_q[gb] & ~clr[gb]); // [RQ10] [RQ11]
      end
   endgenerate

   // ****************************************
   // next values
   // ****************************************
   reg ack_d;
   reg [31:0] dat_d;
   reg [15:0] mask_d;
   reg [7:0] en_d;
   reg [7:0] bsel_d;
   reg irq_d;

   always @* begin
      // one wait state: ack one cycle after the request is seen, then dropped
      ack_d = req;
      // read data holds until the next request, so a slow master still finds it
      if (req) begin
         dat_d = rd;
      end else begin
         dat_d = dat_o;
      end
   end

   always @* begin
      if (wr_mask) begin
         mask_d = (mask_q & ~wmask) | (dat_i[15:0] & wmask);
      end else begin
         mask_d = mask_q;
      end
   end

   always @* begin
      // an enable rising edge reloads the working address inside the channel
      if (wr_en) begin
         en_d = dat_i[7:0];
      end else begin
         en_d = en_q;
      end
      if (wr_bsel) begin
         bsel_d = dat_i[15:8];
      end else begin
         bsel_d = bsel_q;
      end
   end

   always @* begin
      // irq follows the flags of the same edge, so it never lags a clear by a cycle
      irq_d = |(stat_d & mask_q);
   end

   // ****************************************
   // bus registers
   // ****************************************
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else if (ce_i) begin
         ack_o <= ack_d;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h00000000;
      end else if (ce_i) begin
         dat_o <= dat_d;
      end
   end

   // ****************************************
   // status, mask and control registers
   // ****************************************
   always @(posedge clk_i) begin
      if (rst_i) begin
         stat_q <= `DACR_RST16; // [RQ9]
      end else if (ce_i) begin
         stat_q <= stat_d;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         mask_q <= `DACR_RST16;
      end else if (ce_i) begin
         mask_q <= mask_d;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         en_q <= `DACR_RST8;
      end else if (ce_i) begin
         en_q <= en_d;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         bsel_q <= `DACR_RST8;
      end else if (ce_i) begin
         bsel_q <= bsel_d;
      end
   end

   // ****************************************
   // channel outputs
   // ****************************************
   // done is registered, so it trails the final transfer by one cycle
   always @(posedge clk_i) begin
      if (rst_i) begin
         done_o <= `DACR_RST8;
      end else if (ce_i) begin
         done_o <= done_w;
      end
   end

   // level output: stays high while any unmasked flag is set
   always @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else if (ce_i) begin
         irq_o <= irq_d;
      end
   end
endmodule // dacr_top

// ===== test/dacr_peer.sv
module dacr_peer (
   input wire logic clk_i,
   input wire logic slow_i,
   input wire logic [7:0] x_i, p_i, c_i,
   output logic [7:0] xfer_o = 8'h00, pcol_o = 8'h00, xcol_o = 8'h00
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] late = 8'h00;
   // slow mode answers a cycle late, like a busy peripheral
   always @(posedge clk_i) begin
      late <= x_i;
      xfer_o <= slow_i ? late : x_i;
      pcol_o <= p_i;
      xcol_o <= c_i;
   end
endmodule // dacr_peer

// ===== test/dacr_props_properties.sv
module dacr_props (
   input wire clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o,
   input wire [7:0] adr_i, xfer_i, pcol_i, xcol_i, done_o,
   input wire [31:0] dat_o
);
   timeunit 1ns;
   timeprecision 1ps;
   wire wr = stb_i & we_i;
   wire ev = wr | (|pcol_i) | (|xcol_i);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req; cyc_i && stb_i && !ack_o; endsequence
   sequence s_cnt; ack_o && $past(!we_i && !adr_i[7] && adr_i[3:0] == 4'hC); endsequence
   sequence s_st; ack_o && $past(!we_i && adr_i == 8'h80); endsequence
   property p_ack; s_req |=> ack_o; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_ack1; ack_o |=> !ack_o; endproperty
   a_ack1: assert property (p_ack1) else $error("long ack");
   property p_cnt; s_cnt |-> dat_o[31:10] == 22'h0; endproperty
   a_cnt: assert property (p_cnt) else $error("count high bits");
   property p_st; s_st |-> dat_o[31:16] == 16'h0; endproperty
   a_st: assert property (p_st) else $error("status high bits");
   property p_rst; $past(rst_i) |-> !irq_o && done_o == 8'h00 && dat_o == 32'h0; endproperty
   a_rst: assert property (p_rst) else $error("reset values");
   property p_up; $rose(irq_o) |-> $past(ev) || $past(ev, 2); endproperty
   a_up: assert property (p_up) else $error("irq rose alone");
   // a one-edge reset may drop irq, so that edge is excused
   property p_dn; $fell(irq_o) |-> $past(wr) || $past(wr, 2) || $past(rst_i); endproperty
   a_dn: assert property (p_dn) else $error("irq fell alone");
   property p_done; |done_o |-> $past(|xfer_i) || $past(|xfer_i, 2); endproperty
   a_done: assert property (p_done) else $error("done alone");
endmodule // dacr_props
bind dacr_top dacr_props u_props (.*);

// ===== test/tb.sv
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin miscompares++; \
   $display("mismatch %s exp %h seen %h", n, e, s); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, slow = 0, ack_o, irq_o;
   logic [7:0] adr_i = 0, xq = 0, pq = 0, cq = 0, b, xfer_i, pcol_i, xcol_i, done_o;
   logic [3:0] sel_i = 4'hF;
   logic [31:0] dat_i = 0, dat_o, rd;
   logic [15:0] pri, sec, pad, base;
   logic [9:0] cnt;
   int miscompares = 0, tests_run = 0, dn = 0, ch = 0;
   initial forever #5 clk_i = ~clk_i;
   always @(posedge clk_i) if (done_o[ch] === 1'b1) dn++;
   dacr_peer u_peer (.clk_i(clk_i), .slow_i(slow), .x_i(xq), .p_i(pq), .c_i(cq), .xfer_o(xfer_i),
      .pcol_o(pcol_i), .xcol_o(xcol_i));
   dacr_top dut (.*);
   task give_verdict;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   function automatic logic [15:0] exp_work(input logic [15:0] start, input logic [9:0] steps);
      return start + 16'(2 * steps);
   endfunction
   function automatic logic [31:0] exp_flags(input int c);
      return {16'h0000, {2{8'h01 << c}}};
   endfunction
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
      do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 20);
      rd = dat_o;
      {cyc_i, stb_i} <= 2'b00;
      if (n >= 20) begin miscompares++; give_verdict; end
   endtask
   task rc(input logic [7:0] a, input logic [31:0] e, input string n);
      wb(0, a, 0);
      `CHK(n, e, rd)
   endtask
   task xf(input int k);
      repeat (k) begin
         @(posedge clk_i) xq <= 8'h01 << ch;
         @(posedge clk_i) xq <= 8'h00;
         repeat (3) @(posedge clk_i);
      end
   endtask
   initial begin
      void'($urandom(48803));
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      wb(1, 8'h90, '1);
      wb(1, 8'h80, '1);
      for (int a = 0; a < 8'h94; a += 4) rc(8'(a), 0, "reset");
      // a collision while the clock enable is low must leave no flag behind
      @(posedge clk_i) ce_i <= 0;
      @(posedge clk_i) cq <= 8'h01;
      @(posedge clk_i) cq <= 8'h00;
      repeat (2) @(posedge clk_i);
      ce_i <= 1;
      rc(8'h80, 0, "frozen");
      $display("test reset done");
      for (int t = 0; t < 6; t++) begin
         ch = $urandom % 8;
         b = 8'(ch * 16);
         {pri, sec, pad} = {$urandom, 16'($urandom)};
         cnt = (t == 0) ? 10'h0 : (t == 1) ? 10'h3FF : 10'($urandom % 5);
         dn = 0;
         slow <= t[0];
         wb(1, b, pri);
         wb(1, b + 4, sec);
         wb(1, b + 8, pad);
         wb(1, b + 12, {22'($urandom), cnt});
         rc(b + 8, pad, "periph");
         rc(b + 12, cnt, "count");
         base = t[1] ? sec : pri;
         wb(1, 8'h88, (32'(t[1]) << (ch + 8)) | (32'h1 << ch));
         rc(b, base, "pri read");
         rc(b + 4, base, "sec read");
         xf(cnt);
         rc(b, exp_work(base, cnt), "stepped");
         `CHK("early done", 0, dn)
         xf(1);
         rc(b, base, "reloaded");
         `CHK("done", 1, dn)
         wb(1, 8'h88, 0);
         @(posedge clk_i) {pq, cq} <= {2{8'h01 << ch}};
         @(posedge clk_i) {pq, cq} <= 16'h0;
         rc(8'h80, exp_flags(ch), "flags");
         `CHK("irq masked", 1'b0, irq_o)
         wb(1, 8'h84, 32'h1 << ch);
         wb(0, 8'h90, 0);
         `CHK("irq set", 1'b1, irq_o)
         wb(1, 8'h80, '1);
         rc(8'h80, 0, "cleared");
         `CHK("irq clear", 1'b0, irq_o)
         wb(1, 8'h84, 0);
         $display("test %0d done", t);
      end
      give_verdict;
   end
endmodule // tb
